//--- design/hscs_consts.svh
// Offsets, reset values, field positions and the averaging sample count for the block.
`ifndef HSCS_CONSTS_SVH
`define HSCS_CONSTS_SVH
`define HSCS_CMD_SWITCH 8'h01
`define HSCS_CMD_CLEAR 8'h03
`define HSCS_CMD_FEATURE 8'h19
`define HSCS_CMD_OUT_LOW 8'h43
`define HSCS_CMD_HEAT_FAULT 8'h4F
`define HSCS_CMD_HEAT_WARN 8'h51
`define HSCS_CMD_IN_HIGH 8'h57
`define HSCS_CMD_IN_LOW 8'h58
`define HSCS_CMD_SUMMARY 8'h78
`define HSCS_SW_ON 8'h80
`define HSCS_SW_OFF 8'h00
`define HSCS_FEATURE_VAL 8'hB0
`define HSCS_OUT_LOW_RST 12'h000
`define HSCS_HEAT_FAULT_RST 12'h960
`define HSCS_HEAT_WARN_RST 12'h7D0
`define HSCS_IN_HIGH_RST 12'hFFF
`define HSCS_IN_LOW_RST 12'h000
`define HSCS_LIMIT_OFF_HI 12'hFFF
`define HSCS_LIMIT_OFF_LO 12'h000
`define HSCS_BIT_OFF 6
`define HSCS_BIT_INLOW 3
`define HSCS_BIT_TEMP 2
`define HSCS_BIT_COMM 1
`define HSCS_BIT_OTHER 0
`define HSCS_AVG_COUNT 16
`endif

//--- design/hscs_pkg.sv
// Types shared by the command and status logic.
package hscs_pkg;
   // One measurement set, each valid on its own strobe.
   typedef struct packed {
      logic outVoltValid;
      logic [11:0] outVolt;
      logic inVoltValid;
      logic [11:0] inVolt;
      logic tempValid;
      logic [11:0] temp;
   } hscs_meas_t;
   // Latched warning and fault flags.
   typedef struct packed {
      logic outLowWarn;
      logic heatFault;
      logic heatWarn;
      logic inHighWarn;
      logic inLowWarn;
      logic inLowFault;
      logic commFault;
   } hscs_flags_t;
   // Switch-control sequence: tracks an off code awaiting an on code.
   typedef enum logic [0:0] {
      HSCS_SEQ_IDLE = 1'b0,
      HSCS_SEQ_OFF_SEEN = 1'b1
   } hscs_seq_t;
endpackage : hscs_pkg

//--- design/hscs_core.sv
// Command interpreter and status flags of the hot-swap controller.
//
// Behaviour
// - 80h switches on, 00h off; on at reset.
// - Switch command restarts; only byte writes taken.
// - Off then on clears all flags.
// - Bare on after fault keeps flags.
// - Fault clear resets flags, releases alert.
// - Present condition re-asserts alert at once.
// - Fault clear never turns switch on.
// - Feature report reads B0h.
// - Output voltage below nonzero limit warns.
// - Overheat fault turns switch off, alerts.
// - Restart after overheat only when cooled.
// - Temperature is average of 16 samples.
// - Overheat warning alerts, keeps switch on.
// - Input voltage above limit warns.
// - Input voltage below nonzero limit warns.
// - Summary flags clear only after clear, off-on or first lockout exit.
// - Bit 6 high whenever switch off.
// - Summary bit map, unused bits zero.
// - Input-low flags set from reset until first lockout exit, clear or off-on.
`timescale 1ns/1ps
`default_nettype none
`include "hscs_consts.svh"

module hscs_core (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Decoded command port from the serial front end.
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [1:0] cmdLen,
   input wire logic [7:0] cmdCode,
   input wire logic [15:0] cmdData,
   input wire logic commErr,
   output logic [15:0] rdData_reg,
   output logic rdValid_reg,
   // Raw measurements and lockout state.
   input wire hscs_pkg::hscs_meas_t meas,
   input wire logic uvloClearPin,
   // Device outputs.
   output logic switchOn_reg,
   output logic alertLine_n_reg
);
   ////////////////////////////////////////////////////////////////////////
   logic [11:0] outLowLvl_reg, heatFaultLvl_reg, heatWarnLvl_reg;
   logic [11:0] inHighLvl_reg, inLowLvl_reg;
   hscs_pkg::hscs_flags_t flags_reg, flags_next, hits;
   hscs_pkg::hscs_seq_t seq_reg;
   logic [15:0] tempSum_reg;
   logic [4:0] tempCnt_reg;
   logic [11:0] tempAvg_reg;
   logic tempAvgValid_reg;
   logic uvloMeta_reg, uvloSync_reg, uvloSeen_reg;
   logic otherFlag;
   logic [7:0] summary;

   // Transaction shapes: byte write, send byte, word write.
   wire wrByte = cmdValid && cmdWrite && cmdLen == 2'd1;
   wire wrSend = cmdValid && cmdWrite && cmdLen == 2'd0;
   wire wrWord = cmdValid && cmdWrite && cmdLen == 2'd2;
   wire rdByte = cmdValid && !cmdWrite && cmdLen == 2'd1;
   wire rdWord = cmdValid && !cmdWrite && cmdLen == 2'd2;
   wire swWr = wrByte && cmdCode == `HSCS_CMD_SWITCH;
   wire onCode = swWr && cmdData[7:0] == `HSCS_SW_ON;
   wire offCode = swWr && cmdData[7:0] == `HSCS_SW_OFF;
   wire clearCmd = wrSend && cmdCode == `HSCS_CMD_CLEAR;
   wire seqClear = onCode && seq_reg == hscs_pkg::HSCS_SEQ_OFF_SEEN;
   wire wipe = clearCmd || seqClear;
   // cooled before restart
   // The last average is held, so a hot reading blocks a restart until
   // a cooler average arrives; the valid pulse alone would let it through.
   wire cool = tempAvg_reg <= heatFaultLvl_reg ||
      heatFaultLvl_reg == `HSCS_LIMIT_OFF_HI;
   wire limWr = wrWord;

   ////////////////////////////////////////////////////////////////////////
   // Synchronise the lockout indication, which comes from analog logic.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uvloMeta_reg <= 1'b0;
         uvloSync_reg <= 1'b0;
      end else begin
         uvloMeta_reg <= uvloClearPin;
         uvloSync_reg <= uvloMeta_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tempSum_reg <= 16'h0000;
         tempCnt_reg <= 5'd0;
         tempAvg_reg <= 12'h000;
         tempAvgValid_reg <= 1'b0;
      end else begin
         tempAvgValid_reg <= 1'b0;
         if (meas.tempValid) begin
            if (tempCnt_reg == 5'(`HSCS_AVG_COUNT - 1)) begin
               tempAvg_reg <= 12'((tempSum_reg + 16'(meas.temp)) >> 4);
               tempAvgValid_reg <= 1'b1;
               tempSum_reg <= 16'h0000;
               tempCnt_reg <= 5'd0;
            end else begin
               tempSum_reg <= tempSum_reg + 16'(meas.temp);
               tempCnt_reg <= tempCnt_reg + 5'd1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Threshold hits; each compare runs only on its own fresh sample.
   always_comb begin
      hits = '0;
      hits.outLowWarn = meas.outVoltValid &&
         outLowLvl_reg != `HSCS_LIMIT_OFF_LO && meas.outVolt < outLowLvl_reg;
      hits.heatFault = tempAvgValid_reg &&
         heatFaultLvl_reg != `HSCS_LIMIT_OFF_HI &&
         tempAvg_reg > heatFaultLvl_reg;
      hits.heatWarn = tempAvgValid_reg &&
         heatWarnLvl_reg != `HSCS_LIMIT_OFF_HI &&
         tempAvg_reg > heatWarnLvl_reg;
      hits.inHighWarn = meas.inVoltValid &&
         inHighLvl_reg != `HSCS_LIMIT_OFF_HI && meas.inVolt > inHighLvl_reg;
      hits.inLowWarn = meas.inVoltValid &&
         inLowLvl_reg != `HSCS_LIMIT_OFF_LO && meas.inVolt < inLowLvl_reg;
      hits.commFault = commErr;
   end

   always_comb begin
      flags_next = wipe ? hscs_pkg::hscs_flags_t'('0) : flags_reg;
      if (uvloSync_reg && !uvloSeen_reg) begin
         flags_next.inLowFault = 1'b0;
         flags_next.inLowWarn = 1'b0;
      end
      flags_next = flags_next | hits;
   end

   // Flags, lockout memory and the switch-control sequence.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= '0;
         flags_reg.inLowFault <= 1'b1;
         flags_reg.inLowWarn <= 1'b1;
         uvloSeen_reg <= 1'b0;
         seq_reg <= hscs_pkg::HSCS_SEQ_IDLE;
      end else begin
         flags_reg <= flags_next;
         if (uvloSync_reg)
            uvloSeen_reg <= 1'b1;
         if (offCode)
            seq_reg <= hscs_pkg::HSCS_SEQ_OFF_SEEN;
         else if (onCode)
            seq_reg <= hscs_pkg::HSCS_SEQ_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Threshold registers; limits take word writes only.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         outLowLvl_reg <= `HSCS_OUT_LOW_RST;
         heatFaultLvl_reg <= `HSCS_HEAT_FAULT_RST;
         heatWarnLvl_reg <= `HSCS_HEAT_WARN_RST;
         inHighLvl_reg <= `HSCS_IN_HIGH_RST;
         inLowLvl_reg <= `HSCS_IN_LOW_RST;
      end else if (limWr) begin
         if (cmdCode == `HSCS_CMD_OUT_LOW)
            outLowLvl_reg <= cmdData[11:0];
         else if (cmdCode == `HSCS_CMD_HEAT_FAULT)
            heatFaultLvl_reg <= cmdData[11:0];
         else if (cmdCode == `HSCS_CMD_HEAT_WARN)
            heatWarnLvl_reg <= cmdData[11:0];
         else if (cmdCode == `HSCS_CMD_IN_HIGH)
            inHighLvl_reg <= cmdData[11:0];
         else if (cmdCode == `HSCS_CMD_IN_LOW)
            inLowLvl_reg <= cmdData[11:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         switchOn_reg <= 1'b1;
      else if (hits.heatFault)
         switchOn_reg <= 1'b0;
      else if (offCode)
         switchOn_reg <= 1'b0;
      else if (onCode && cool)
         switchOn_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // summary bit map
   assign otherFlag = flags_reg.outLowWarn | flags_reg.inHighWarn |
      flags_reg.inLowWarn;
   always_comb begin
      summary = 8'h00;
      summary[`HSCS_BIT_OFF] = !switchOn_reg;
      summary[`HSCS_BIT_INLOW] = flags_reg.inLowFault;
      summary[`HSCS_BIT_TEMP] = flags_reg.heatFault | flags_reg.heatWarn;
      summary[`HSCS_BIT_COMM] = flags_reg.commFault;
      summary[`HSCS_BIT_OTHER] = otherFlag;
   end

   // Read answers one cycle after the request; unknown codes return zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_reg <= 16'h0000;
         rdValid_reg <= 1'b0;
      end else begin
         rdValid_reg <= rdByte || rdWord;
         rdData_reg <= 16'h0000;
         if (rdByte && cmdCode == `HSCS_CMD_FEATURE)
            rdData_reg <= {8'h00, `HSCS_FEATURE_VAL};
         else if (rdByte && cmdCode == `HSCS_CMD_SWITCH)
            rdData_reg <= {8'h00, switchOn_reg ? `HSCS_SW_ON : `HSCS_SW_OFF};
         else if (rdByte && cmdCode == `HSCS_CMD_SUMMARY)
            rdData_reg <= {8'h00, summary};
         else if (rdWord && cmdCode == `HSCS_CMD_OUT_LOW)
            rdData_reg <= {4'h0, outLowLvl_reg};
         else if (rdWord && cmdCode == `HSCS_CMD_HEAT_FAULT)
            rdData_reg <= {4'h0, heatFaultLvl_reg};
         else if (rdWord && cmdCode == `HSCS_CMD_HEAT_WARN)
            rdData_reg <= {4'h0, heatWarnLvl_reg};
         else if (rdWord && cmdCode == `HSCS_CMD_IN_HIGH)
            rdData_reg <= {4'h0, inHighLvl_reg};
         else if (rdWord && cmdCode == `HSCS_CMD_IN_LOW)
            rdData_reg <= {4'h0, inLowLvl_reg};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         alertLine_n_reg <= 1'b1;
      else
         alertLine_n_reg <= !(|flags_next);
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks kept beside the logic.
   sequence s_offWrite;
      offCode;
   endsequence
   sequence s_onAfter;
      onCode && seq_reg == hscs_pkg::HSCS_SEQ_OFF_SEEN;
   endsequence
   property p_onCode;
      @(posedge clk) disable iff (!rst_n)
      onCode && cool && !hits.heatFault |=> switchOn_reg;
   endproperty
   a_onCode: assert property (p_onCode) else $error("on code ignored");
   property p_offCode;
      @(posedge clk) disable iff (!rst_n) offCode |=> !switchOn_reg;
   endproperty
   a_offCode: assert property (p_offCode) else $error("off code ignored");
   property p_seqClear;
      @(posedge clk) disable iff (!rst_n)
      s_offWrite ##[1:1000] s_onAfter |=> flags_reg == $past(hits);
   endproperty
   a_seqClear: assert property (p_seqClear) else $error("off-on no clear");
   property p_bareOn;
      @(posedge clk) disable iff (!rst_n)
      onCode && !seqClear && !clearCmd && flags_reg.heatFault
      |=> flags_reg.heatFault;
   endproperty
   a_bareOn: assert property (p_bareOn) else $error("bare on cleared");
   property p_clear;
      @(posedge clk) disable iff (!rst_n)
      clearCmd && hits == '0 && uvloSeen_reg |=> alertLine_n_reg;
   endproperty
   a_clear: assert property (p_clear) else $error("clear left alert");
   property p_clearKeepsOff;
      @(posedge clk) disable iff (!rst_n)
      clearCmd && !switchOn_reg && !onCode |=> !switchOn_reg;
   endproperty
   a_clearKeepsOff: assert property (p_clearKeepsOff)
      else $error("clear restarted");
   property p_heat;
      @(posedge clk) disable iff (!rst_n)
      hits.heatFault |=> !switchOn_reg && flags_reg.heatFault && !alertLine_n_reg;
   endproperty
   a_heat: assert property (p_heat) else $error("overheat missed");
   // The read answer, not the internal byte, must carry the off bit.
   property p_offBit;
      @(posedge clk) disable iff (!rst_n)
      rdByte && cmdCode == `HSCS_CMD_SUMMARY |=>
         rdData_reg[`HSCS_BIT_OFF] == !$past(switchOn_reg) &&
         rdData_reg[7] == 1'b0 && rdData_reg[5:4] == 2'h0;
   endproperty
   a_offBit: assert property (p_offBit) else $error("off bit wrong");
   property p_alert;
      @(posedge clk) disable iff (!rst_n)
      $rose(|flags_reg) |-> !alertLine_n_reg;
   endproperty
   a_alert: assert property (p_alert) else $error("alert not low");
endmodule : hscs_core

`default_nettype wire

//--- test/hscs_host.sv
// Host model that issues decoded commands to the block.
`timescale 1ns/1ps
`default_nettype none

module hscs_host (
   // Clock.
   input wire logic clk,
   // Command side.
   output logic cmdValid,
   output logic cmdWrite,
   output logic [1:0] cmdLen,
   output logic [7:0] cmdCode,
   output logic [15:0] cmdData,
   // Answer side.
   input wire logic [15:0] rdData,
   input wire logic rdValid
);
   // Idle bus before the first command.
   initial begin
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdLen = 2'h0;
      cmdCode = 8'h00;
      cmdData = 16'h0000;
   end

   // One transfer; on release code and data flip so stale values never look valid.
   task automatic xfer(input logic w, input logic [1:0] l,
         input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdWrite <= w;
      cmdLen <= l;
      cmdCode <= c;
      cmdData <= d;
      @(posedge clk);
      cmdValid <= 1'b0;
      cmdCode <= ~c;
      cmdData <= ~d;
      #1;
      q = rdValid ? rdData : 16'hDEAD;
   endtask : xfer

   task automatic limWr(input logic [7:0] c, input logic [15:0] d);
      logic [15:0] q;
      xfer(1'b1, 2'h2, c, d, q);
   endtask : limWr

   task automatic swWr(input logic [7:0] d);
      logic [15:0] q;
      xfer(1'b1, 2'h1, 8'h01, {8'h00, d}, q);
   endtask : swWr

   task automatic sendClear();
      logic [15:0] q;
      xfer(1'b1, 2'h0, 8'h03, 16'h0000, q);
   endtask : sendClear
endmodule : hscs_host
`default_nettype wire

//--- test/hot_swap_command_status_logic_bench.sv
// Self-checking bench for the hot-swap command and status logic.
`timescale 1ns/1ps
`default_nettype none

module hot_swap_command_status_logic_bench;
   logic clk, rst_n, commErr, uvloClearPin, mOn, mOff;
   logic ol, hf, hw, ih, ilw, ilf, cm;
   hscs_pkg::hscs_meas_t meas;
   wire cmdValid, cmdWrite, rdValid, swOn, alertN;
   wire [1:0] cmdLen;
   wire [7:0] cmdCode;
   wire [15:0] cmdData, rdData;
   int bad_count, checks, cyc, mAvg, hfLim, hwLim, ihLim, ilLim, olLim;
   logic [15:0] q;
   logic [11:0] r;

   hscs_core u_dut (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdLen(cmdLen), .cmdCode(cmdCode),
      .cmdData(cmdData), .commErr(commErr), .rdData_reg(rdData),
      .rdValid_reg(rdValid), .meas(meas), .uvloClearPin(uvloClearPin),
      .switchOn_reg(swOn), .alertLine_n_reg(alertN));
   hscs_host u_host (.clk(clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
      .cmdLen(cmdLen), .cmdCode(cmdCode), .cmdData(cmdData),
      .rdData(rdData), .rdValid(rdValid));

   ////////////////////////////////////////////////////////////////////////
   // Clock and a cycle ceiling so a hang still ends in the report.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare tasks count every check.
   task automatic chk(input string n, input logic [15:0] e,
         input logic [15:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic chkPin(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask : chkPin
   task automatic rd(input logic [7:0] c, input logic [1:0] l,
         input logic [15:0] e);
      u_host.xfer(1'b0, l, c, 16'h0000, q);
      chk($sformatf("read %h", c), e, q);
   endtask : rd
   // Summary, alert and switch against the model.
   task automatic look();
      rd(8'h78, 2'h1, {9'h000, !mOn, 2'h0, ilf, hf | hw, cm, ol | ih | ilw});
      chkPin("alert", !(ol | hf | hw | ih | ilw | ilf | cm), alertN);
      chkPin("switch", mOn, swOn);
   endtask : look

   ////////////////////////////////////////////////////////////////////////
   // Model updates, applied as each stimulus completes.
   task automatic clr();
      {ol, hf, hw, ih, ilw, ilf, cm} = 7'h00;
   endtask : clr
   task automatic sendClr();
      u_host.sendClear();
      clr();
      @(posedge clk);
      #1;
   endtask : sendClr
   task automatic sw(input logic [7:0] d);
      u_host.swWr(d);
      if (d == 8'h00) begin
         mOn = 1'b0;
         mOff = 1'b1;
      end else if (d == 8'h80 && !(mAvg > hfLim)) begin
         if (mOff) clr();
         mOn = 1'b1;
         mOff = 1'b0;
      end
      @(posedge clk);
      #1;
   endtask : sw
   task automatic setLim(input logic [7:0] c, input logic [15:0] d);
      u_host.limWr(c, d);
      rd(c, 2'h2, {4'h0, d[11:0]});
      case (c)
         8'h43: olLim = d[11:0];
         8'h4F: hfLim = d[11:0];
         8'h51: hwLim = d[11:0];
         8'h57: ihLim = d[11:0];
         default: ilLim = d[11:0];
      endcase
   endtask : setLim
   task automatic volt(input logic isIn, input logic [11:0] v);
      @(posedge clk);
      meas.inVoltValid <= isIn;
      meas.outVoltValid <= !isIn;
      meas.inVolt <= v;
      meas.outVolt <= v;
      @(posedge clk);
      meas.inVoltValid <= 1'b0;
      meas.outVoltValid <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      if (isIn && ihLim != 12'hFFF && v > ihLim) ih = 1'b1;
      if (isIn && ilLim != 0 && v < ilLim) ilw = 1'b1;
      if (!isIn && olLim != 0 && v < olLim) ol = 1'b1;
   endtask : volt
   // Last sample is low, so only a true average crosses the limit.
   task automatic temp16(input logic [11:0] a, input logic [11:0] b);
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         meas.tempValid <= 1'b1;
         meas.temp <= i[0] ? a : b;
      end
      @(posedge clk);
      meas.tempValid <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      mAvg = (8 * a + 8 * b) >> 4;
      if (hfLim != 12'hFFF && mAvg > hfLim) begin
         hf = 1'b1;
         mOn = 1'b0;
      end
      if (hwLim != 12'hFFF && mAvg > hwLim) hw = 1'b1;
   endtask : temp16

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      rst_n = 1'b0;
      commErr = 1'b0;
      uvloClearPin = 1'b0;
      meas = '0;
      {mOn, mOff, mAvg, olLim, ilLim} = {1'b1, 1'b0, 32'h0, 32'h0, 32'h0};
      {hfLim, hwLim, ihLim} = {32'h960, 32'h7D0, 32'hFFF};
      clr();
      {ilw, ilf} = 2'h3;
      void'($urandom(39));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      look();
      rd(8'h19, 2'h1, 16'h00B0);
      rd(8'h01, 2'h1, 16'h0080);
      rd(8'h43, 2'h2, 16'h0000);
      rd(8'h4F, 2'h2, 16'h0960);
      rd(8'h51, 2'h2, 16'h07D0);
      rd(8'h57, 2'h2, 16'h0FFF);
      rd(8'h58, 2'h2, 16'h0000);
      $display("test reset done");
      @(posedge clk);
      uvloClearPin <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      {ilw, ilf} = 2'h0;
      look();
      $display("test lockout done");
      setLim(8'h57, 16'($urandom));
      r = 12'h400 + 12'($urandom % 256);
      setLim(8'h57, {4'h0, r});
      volt(1'b1, r);
      look();
      volt(1'b1, r + 12'h001);
      setLim(8'h58, 16'h0100);
      volt(1'b1, 12'h0FF);
      setLim(8'h43, 16'h0100);
      volt(1'b0, 12'h050);
      volt(1'b0, 12'h200);
      @(posedge clk);
      commErr <= 1'b1;
      @(posedge clk);
      commErr <= 1'b0;
      cm = 1'b1;
      look();
      sendClr();
      look();
      volt(1'b1, 12'h0FF);
      look();
      setLim(8'h58, 16'h0000);
      sendClr();
      $display("test warnings done");
      u_host.xfer(1'b1, 2'h2, 8'h01, 16'h0000, q);
      sw(8'h55);
      look();
      sw(8'h00);
      look();
      sw(8'h80);
      setLim(8'h4F, 16'h0100);
      temp16(12'h000, 12'h202);
      look();
      sw(8'h80);
      sendClr();
      look();
      temp16(12'h000, 12'h202);
      temp16(12'h010, 12'h010);
      sw(8'h80);
      look();
      sw(8'h00);
      sw(8'h80);
      look();
      $display("test switch done");
      setLim(8'h4F, 16'h0FFF);
      setLim(8'h51, 16'h0100);
      temp16(12'h000, 12'h202);
      look();
      sendClr();
      look();
      $display("test overheat warn done");
      report_and_stop();
   end
endmodule : hot_swap_command_status_logic_bench
`default_nettype wire
